// [rtl/frc_cfg.svh]
`ifndef FRC_CFG_SVH
`define FRC_CFG_SVH

`define FRC_AW        9
`define FRC_OFS_STAT  9'h1b2
`define FRC_OFS_CTL0  9'h1b4
`define FRC_OFS_CTL1  9'h1b5

`define FRC_CTL0_RST  8'h00
`define FRC_CTL1_RST  8'h00
`define FRC_ZERO8     8'h00

`define FRC_B_RDYI    0
`define FRC_B_AERI    1
`define FRC_B_LOCK    2
`define FRC_B_PERR    4
`define FRC_B_EERR    5
`define FRC_B_SUSP    6
`define FRC_B_RDY     7

`define FRC_B_REN     1
`define FRC_B_HOLD    2
`define FRC_B_STOP    3
`define FRC_B_SRST    4
`define FRC_B_ERIE    5
`define FRC_B_AEIE    6
`define FRC_B_RDIE    7

`define FRC_B_LKD     3
`define FRC_B_INH     4
`define FRC_NDF       4

`endif

// [rtl/frc_pkg.sv]
package frc_pkg;

  // Command offered by the software-command decoder
  typedef struct packed {
    logic       req;
    logic       erase;
    logic [2:0] blk;
  } frc_cmd_t;

  // Status and events from the flash core
  typedef struct packed {
    logic busy;
    logic suspended;
    logic lockData;
    logic progDone;
    logic eraseDone;
    logic progErr;
    logic eraseErr;
    logic cmdErr;
  } frc_core_t;

  typedef enum logic [2:0] {
    FRC_IDLE = 3'b001,
    FRC_ARM  = 3'b010,
    FRC_DONE = 3'b100
  } frc_seq_t;

endpackage

// [rtl/flash_rewrite_control.sv]
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "frc_cfg.svh"

module flash_rewrite_control
  import frc_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             clkEn,
  input  wire logic [`FRC_AW-1:0] busAddr,
  input  wire logic [7:0]       busWdata,
  input  wire logic             busWr,
  input  wire logic             busRd,
  output logic      [7:0]       busRdata,
  input  wire frc_cmd_t         cmdIn,
  output logic                  cmdAccept,
  output logic                  cmdDrop,
  input  wire frc_core_t        core,
  input  wire logic             statusClear,
  input  wire logic             accessHit,
  input  wire logic             sleepReq,
  output logic                  seqReset,
  output logic                  flashStop,
  output logic                  romReadAllow,
  output logic                  flashPowerOff,
  output logic                  cpuHoldMode,
  output logic                  lockBypass,
  output logic                  errIrq,
  output logic                  accessIrq,
  output logic                  readyIrq
);

  logic       rstSync1_r;
  logic       rstSync2_r;
  logic       rstn;

  // Control 0 fields
  logic       rewriteEn_r;
  logic       holdSel_r;
  logic       stopBit_r;
  logic       errIe_r;
  logic       accIe_r;
  logic       rdyIe_r;

  // Control 1 fields
  logic       lockDis_r;
  logic [`FRC_NDF-1:0] inhibit_r;

  // Status flags
  logic       progErr_r;
  logic       eraseErr_r;
  logic       rdyReq_r;
  logic       accReq_r;
  logic       busyD_r;
  logic       suspD_r;
  logic       seqReset_r;
  logic       errIrq_r;

  // Previous write, for the zero-then-one unlock
  logic       lastWrValid_r;
  logic [`FRC_AW-1:0] lastWrAddr_r;
  logic [7:0] lastWrData_r;

  frc_seq_t   rstSeq_r;
  frc_seq_t   rstSeq_nxt;

  logic       wrCtl0;
  logic       wrCtl1;
  logic       wrStat;
  logic       stopEff;
  logic       readyRise;
  logic       suspRise;
  logic       anyErr;
  logic       srstHit;
  logic       lockClr;
  logic [7:0] statusByte;
  logic [7:0] ctl0Byte;
  logic [7:0] ctl1Byte;

  // True when bit b of this write goes to pol right after a write of the opposite value to the same address
  function automatic logic armedFlip(
    input logic [`FRC_AW-1:0] a,
    input logic [7:0]         d,
    input int                 b,
    input logic               pol,
    input logic               v,
    input logic [`FRC_AW-1:0] pa,
    input logic [7:0]         pd
  );
    armedFlip = (d[b] == pol) && v && (pa == a) && (pd[b] != pol);
  endfunction

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rstSync1_r <= 1'b0;
      rstSync2_r <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstSync2_r <= rstSync1_r;
    end
  end

  assign rstn = rstSync2_r;

  assign wrCtl0 = busWr && (busAddr == `FRC_OFS_CTL0);
  assign wrCtl1 = busWr && (busAddr == `FRC_OFS_CTL1);
  assign wrStat = busWr && (busAddr == `FRC_OFS_STAT);

  assign stopEff   = stopBit_r && rewriteEn_r;
  assign readyRise = busyD_r && !core.busy;
  assign suspRise  = core.suspended && !suspD_r;
  assign anyErr    = core.progErr || core.eraseErr || core.cmdErr;

  // Forced reset only counts in rewrite mode while busy
  assign srstHit = wrCtl0 && busWdata[`FRC_B_SRST] && rewriteEn_r && core.busy;

  assign lockClr = core.progDone || core.eraseDone || core.cmdErr
                || suspRise || !rewriteEn_r || stopEff || srstHit;

  // Previous-write tracker; any other write breaks the pair
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lastWrValid_r <= 1'b0;
      lastWrAddr_r  <= '0;
      lastWrData_r  <= `FRC_ZERO8;
    end else if (clkEn && busWr) begin
      lastWrValid_r <= 1'b1;
      lastWrAddr_r  <= busAddr;
      lastWrData_r  <= busWdata;
    end
  end

  // Control 0
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rewriteEn_r <= 1'(`FRC_CTL0_RST >> `FRC_B_REN);
      holdSel_r   <= 1'b0;
      stopBit_r   <= 1'b0;
      errIe_r     <= 1'b0;
      accIe_r     <= 1'b0;
      rdyIe_r     <= 1'b0;
    end else if (clkEn && wrCtl0) begin
      // Setting needs a preceding write of zero to the same bit
      if (!busWdata[`FRC_B_REN]) begin
        rewriteEn_r <= 1'b0;
      end else if (armedFlip(busAddr, busWdata, `FRC_B_REN, 1'b1, lastWrValid_r,
                             lastWrAddr_r, lastWrData_r)) begin
        rewriteEn_r <= 1'b1;
      end
      if (!busWdata[`FRC_B_HOLD]) begin
        holdSel_r <= 1'b0;
      end else if (armedFlip(busAddr, busWdata, `FRC_B_HOLD, 1'b1, lastWrValid_r,
                             lastWrAddr_r, lastWrData_r)) begin
        holdSel_r <= 1'b1;
      end
      stopBit_r <= busWdata[`FRC_B_STOP];
      errIe_r   <= busWdata[`FRC_B_ERIE];
      accIe_r   <= busWdata[`FRC_B_AEIE];
      rdyIe_r   <= busWdata[`FRC_B_RDIE];
    end
  end

  // Control 1: lock disable and data-flash inhibits
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lockDis_r <= 1'b0;
    end else if (clkEn) begin
      if (lockClr) begin
        lockDis_r <= 1'b0;
      end else if (wrCtl1) begin
        if (!busWdata[`FRC_B_LKD]) begin
          lockDis_r <= 1'b0;
        end else if (armedFlip(busAddr, busWdata, `FRC_B_LKD, 1'b1, lastWrValid_r,
                               lastWrAddr_r, lastWrData_r)) begin
          lockDis_r <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      inhibit_r <= `FRC_NDF'(`FRC_CTL1_RST >> `FRC_B_INH);
    end else if (clkEn && wrCtl1) begin
      for (int i = 0; i < `FRC_NDF; i++) begin
        // Clearing needs a preceding write of one to the same bit
        if (busWdata[`FRC_B_INH + i]) begin
          inhibit_r[i] <= 1'b1;
        end else if (armedFlip(busAddr, busWdata, `FRC_B_INH + i, 1'b0, lastWrValid_r,
                               lastWrAddr_r, lastWrData_r)) begin
          inhibit_r[i] <= 1'b0;
        end
      end
    end
  end

  // Error flags; a core event beats a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      progErr_r  <= 1'b0;
      eraseErr_r <= 1'b0;
    end else if (clkEn) begin
      if (core.progErr || core.cmdErr) begin
        progErr_r <= 1'b1;
      end else if (statusClear) begin
        progErr_r <= 1'b0;
      end
      if (core.eraseErr || core.cmdErr) begin
        eraseErr_r <= 1'b1;
      end else if (statusClear) begin
        eraseErr_r <= 1'b0;
      end
    end
  end

  // Edge history of busy and suspend
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busyD_r <= 1'b0;
      suspD_r <= 1'b0;
    end else if (clkEn) begin
      busyD_r <= core.busy;
      suspD_r <= core.suspended;
    end
  end

  // Ready request: hardware sets, software may only clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdyReq_r <= 1'b0;
    end else if (clkEn) begin
      if (readyRise && rdyIe_r) begin
        rdyReq_r <= 1'b1;
      end else if (wrStat && !busWdata[`FRC_B_RDYI]) begin
        rdyReq_r <= 1'b0;
      end
    end
  end

  // Access-error request
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      accReq_r <= 1'b0;
    end else if (clkEn) begin
      if ((accIe_r && accessHit && core.busy) || (errIe_r && anyErr)) begin
        accReq_r <= 1'b1;
      end else if (statusClear || (wrStat && !busWdata[`FRC_B_AERI])) begin
        accReq_r <= 1'b0;
      end
    end
  end

  // Error interrupt pulse
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      errIrq_r <= 1'b0;
    end else if (clkEn) begin
      errIrq_r <= errIe_r && anyErr;
    end
  end

  // Forced sequence reset: one-cycle pulse to the sequencer
  always_comb begin
    rstSeq_nxt = rstSeq_r;
    case (rstSeq_r)
      FRC_IDLE: begin
        if (srstHit) begin
          rstSeq_nxt = FRC_ARM;
        end
      end
      FRC_ARM: begin
        rstSeq_nxt = FRC_DONE;
      end
      FRC_DONE: begin
        rstSeq_nxt = FRC_IDLE;
      end
      default: begin
        rstSeq_nxt = FRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstSeq_r <= FRC_IDLE;
    end else if (clkEn) begin
      rstSeq_r <= rstSeq_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      seqReset_r <= 1'b0;
    end else if (clkEn) begin
      seqReset_r <= (rstSeq_nxt == FRC_ARM);
    end
  end

  // Register read views; reserved bits are zero
  always_comb begin
    statusByte                = `FRC_ZERO8;
    statusByte[`FRC_B_RDYI]   = rdyReq_r;
    statusByte[`FRC_B_AERI]   = accReq_r;
    statusByte[`FRC_B_LOCK]   = core.lockData;
    statusByte[`FRC_B_PERR]   = progErr_r;
    statusByte[`FRC_B_EERR]   = eraseErr_r;
    statusByte[`FRC_B_SUSP]   = core.suspended;
    statusByte[`FRC_B_RDY]    = !core.busy;
  end

  always_comb begin
    ctl0Byte               = `FRC_ZERO8;
    ctl0Byte[`FRC_B_REN]   = rewriteEn_r;
    ctl0Byte[`FRC_B_HOLD]  = holdSel_r;
    ctl0Byte[`FRC_B_STOP]  = stopBit_r;
    ctl0Byte[`FRC_B_ERIE]  = errIe_r;
    ctl0Byte[`FRC_B_AEIE]  = accIe_r;
    ctl0Byte[`FRC_B_RDIE]  = rdyIe_r;
  end

  always_comb begin
    ctl1Byte = `FRC_ZERO8;
    ctl1Byte[`FRC_B_LKD] = lockDis_r;
    ctl1Byte[`FRC_B_INH +: `FRC_NDF] = inhibit_r;
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busRdata <= `FRC_ZERO8;
    end else if (clkEn) begin
      if (busRd) begin
        case (busAddr)
          `FRC_OFS_STAT: busRdata <= statusByte;
          `FRC_OFS_CTL0: busRdata <= ctl0Byte;
          `FRC_OFS_CTL1: busRdata <= ctl1Byte;
          default:       busRdata <= `FRC_ZERO8;
        endcase
      end else begin
        busRdata <= `FRC_ZERO8;
      end
    end
  end

  // Command gate; inhibited data-flash blocks drop without error
  always_comb begin
    cmdAccept = 1'b0;
    cmdDrop   = 1'b0;
    if (cmdIn.req) begin
      if (!rewriteEn_r || stopEff) begin
        cmdDrop = 1'b1;
      end else if (cmdIn.blk < 3'(`FRC_NDF) && inhibit_r[cmdIn.blk[1:0]]) begin
        cmdDrop = 1'b1;
      end else begin
        cmdAccept = 1'b1;
      end
    end
  end

  assign seqReset     = seqReset_r;
  assign flashStop    = stopEff;
  // Sequence reset does not fence reads, only the stop bit in rewrite mode does
  assign romReadAllow = !stopEff;
  assign flashPowerOff = stopEff || (sleepReq && !rewriteEn_r);
  assign cpuHoldMode  = rewriteEn_r && holdSel_r;
  assign lockBypass   = lockDis_r;
  assign errIrq       = errIrq_r;
  assign accessIrq    = accReq_r;
  assign readyIrq     = rdyReq_r;

endmodule

// [verif/frc_chk.sv]
`timescale 1ns/1ps
`include "frc_cfg.svh"

module frc_chk
  import frc_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic [8:0] busAddr,
  input wire logic [7:0] busWdata,
  input wire logic       busWr,
  input wire logic       busRd,
  input wire logic [7:0] busRdata,
  input wire frc_cmd_t   cmdIn,
  input wire logic       cmdAccept,
  input wire frc_core_t  core,
  input wire logic       accessHit,
  input wire logic       seqReset,
  input wire logic       flashStop,
  input wire logic       romReadAllow,
  input wire logic       flashPowerOff,
  input wire logic       lockBypass,
  input wire logic       errIrq,
  input wire logic       accessIrq,
  input wire logic       readyIrq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_rom; romReadAllow == !flashStop; endproperty
  property p_stop; flashStop |-> flashPowerOff && !cmdAccept; endproperty
  property p_err; errIrq |-> $past(core.progErr || core.eraseErr || core.cmdErr); endproperty
  property p_rdy; $rose(readyIrq) |-> $past(core.busy, 2) && !$past(core.busy); endproperty
  // The pulse must trace back to a reset write to control 0 while busy and last exactly one cycle
  property p_seq;
    seqReset |-> $past(busWr && busAddr == `FRC_OFS_CTL0 && busWdata[`FRC_B_SRST] && core.busy) ##1 !seqReset;
  endproperty
  property p_lock; core.progDone || core.eraseDone || core.cmdErr |=> !lockBypass; endproperty
  property p_st;
    busRd && busAddr == `FRC_OFS_STAT |=> busRdata[7] == !$past(core.busy) &&
      busRdata[6] == $past(core.suspended) && !busRdata[3];
  endproperty
  property p_rd; !busRd |=> busRdata == 8'h00; endproperty
  property p_aer;
    $rose(accessIrq) |-> $past(accessHit && core.busy || core.progErr || core.eraseErr || core.cmdErr);
  endproperty

  a_rom: assert property (p_rom) else $error("rom read allow wrong");
  a_stop: assert property (p_stop) else $error("stop did not block flash");
  a_err: assert property (p_err) else $error("error irq without error");
  a_rdy: assert property (p_rdy) else $error("ready flag without busy fall");
  a_seq: assert property (p_seq) else $error("sequence reset pulse wrong");
  a_lock: assert property (p_lock) else $error("lock disable not cleared");
  a_st: assert property (p_st) else $error("status read wrong");
  a_rd: assert property (p_rd) else $error("read data outside read cycle");
  a_aer: assert property (p_aer) else $error("access flag without cause");

  c_seq: cover property (seqReset);
  c_rdy: cover property ($rose(readyIrq));
  c_err: cover property (errIrq && accessIrq);
endmodule

bind flash_rewrite_control frc_chk i_chk (.ref_clk, .resetn, .busAddr, .busWdata, .busWr, .busRd, .busRdata,
  .cmdIn, .cmdAccept, .core, .accessHit, .seqReset, .flashStop, .romReadAllow, .flashPowerOff, .lockBypass,
  .errIrq, .accessIrq, .readyIrq);

// [verif/tb_flash_rewrite_control.sv]
`timescale 1ns/1ps
`include "frc_cfg.svh"

module tb_flash_rewrite_control
  import frc_pkg::*;
;
  localparam logic [8:0] ST = `FRC_OFS_STAT;
  localparam logic [8:0] C0 = `FRC_OFS_CTL0;
  localparam logic [8:0] C1 = `FRC_OFS_CTL1;
  logic        ref_clk = 1'b0;
  logic        resetn, clkEn, busWr, busRd, statusClear, accessHit, sleepReq;
  logic [8:0]  busAddr;
  logic [7:0]  busWdata, busRdata;
  frc_cmd_t    cmdIn;
  frc_core_t   core;
  logic        cmdAccept, cmdDrop, seqReset, flashStop, romReadAllow, flashPowerOff;
  logic        cpuHoldMode, lockBypass, errIrq, accessIrq, readyIrq;
  logic [31:0] seed = 32'h00006366;
  int          err_count = 0;
  int          compares = 0;
  int          ev[4] = '{4, 3, 0, 6};

  always #12.5 ref_clk = ~ref_clk;

  flash_rewrite_control i_dut (.ref_clk, .resetn, .clkEn, .busAddr, .busWdata, .busWr, .busRd, .busRdata,
    .cmdIn, .cmdAccept, .cmdDrop, .core, .statusClear, .accessHit, .sleepReq, .seqReset, .flashStop,
    .romReadAllow, .flashPowerOff, .cpuHoldMode, .lockBypass, .errIrq, .accessIrq, .readyIrq);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] stat(logic b, logic e, logic p, logic a, logic r);
    return {~b, 1'b0, e, p, 2'b00, a, r};
  endfunction

  task automatic report_and_stop();
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  // Comb outputs are sampled mid-cycle so the edge's own updates have landed
  task automatic see(string n, logic e, ref logic g);
    @(negedge ref_clk);
    chk(n, {7'h00, e}, {7'h00, g});
    @(posedge ref_clk);
  endtask

  // One-cycle write strobe; the caller must let an edge pass before touching busWr
  task automatic wrq(logic [8:0] a, logic [7:0] d);
    busRd <= 1'b0;
    busWr <= 1'b1;
    busAddr <= a;
    busWdata <= d;
    @(posedge ref_clk);
    busWr <= 1'b0;
  endtask

  // Idle edge after each write keeps strobe assignments in separate time steps
  task automatic wr(logic [8:0] a, logic [7:0] d);
    wrq(a, d);
    @(posedge ref_clk);
  endtask

  task automatic rd(logic [8:0] a, logic [7:0] e, string n);
    busWr <= 1'b0;
    busRd <= 1'b1;
    busAddr <= a;
    @(posedge ref_clk);
    busRd <= 1'b0;
    @(negedge ref_clk);
    chk(n, e, busRdata);
    @(posedge ref_clk);
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    report_and_stop();
  end

  initial begin
    logic [31:0] r;
    logic [3:0]  n;
    {resetn, busWr, busRd, statusClear, accessHit, sleepReq} = 6'h00;
    clkEn = 1'b1;
    busAddr = 9'h000;
    busWdata = 8'h00;
    cmdIn = '0;
    core = '0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(C0, 8'h00, "ctl0");
    rd(C1, 8'h00, "ctl1");
    rd(ST, stat(1'b0, 1'b0, 1'b0, 1'b0, 1'b0), "stat");
    repeat (3) begin
      r = rnd();
      wr({1'b0, r[7:0]}, r[15:8]);
      rd({1'b0, r[7:0]}, 8'h00, "unmapped");
    end
    wr(C0, 8'h02);
    rd(C0, 8'h00, "ctl0");
    cmdIn <= {1'b1, 1'b0, 3'h4};
    see("cmdDrop", 1'b1, cmdDrop);
    wr(C0, 8'h00);
    wr(C0, 8'h06);
    see("cpuHoldMode", 1'b1, cpuHoldMode);
    see("cmdAccept", 1'b1, cmdAccept);
    rd(C0, 8'h06, "ctl0");
    r = rnd();
    n = r[3:0] | 4'h1;
    wr(C1, {n, 4'h0});
    rd(C1, {n, 4'h0}, "ctl1");
    for (int b = 0; b < 4; b++) begin
      cmdIn <= {1'b1, r[b + 8], 3'(b)};
      see("cmdDrop", n[b], cmdDrop);
    end
    wr(C1, 8'h00);
    rd(C1, 8'h00, "ctl1");
    for (int i = 0; i < 4; i++) begin
      wr(C1, 8'h00);
      wr(C1, 8'h08);
      see("lockBypass", 1'b1, lockBypass);
      core[ev[i]] <= 1'b1;
      @(posedge ref_clk);
      core <= '0;
      see("lockBypass", 1'b0, lockBypass);
    end
    statusClear <= 1'b1;
    wr(C0, 8'h00);
    statusClear <= 1'b0;
    wr(C0, 8'h22);
    for (int k = 0; k < 3; k++) begin
      core[2 - k] <= 1'b1;
      @(posedge ref_clk);
      core <= '0;
      see("errIrq", 1'b1, errIrq);
      rd(ST, stat(1'b0, k != 0, k != 1, 1'b1, 1'b0), "stat");
      statusClear <= 1'b1;
      wr(ST, 8'h00);
      statusClear <= 1'b0;
      rd(ST, stat(1'b0, 1'b0, 1'b0, 1'b0, 1'b0), "stat");
    end
    wr(C0, 8'h00);
    wr(C0, 8'h82);
    core.busy <= 1'b1;
    wr(ST, 8'h03);
    rd(ST, stat(1'b1, 1'b0, 1'b0, 1'b0, 1'b0), "stat");
    core.busy <= 1'b0;
    @(posedge ref_clk);
    see("readyIrq", 1'b1, readyIrq);
    rd(ST, stat(1'b0, 1'b0, 1'b0, 1'b0, 1'b1), "stat");
    wr(ST, 8'h00);
    see("readyIrq", 1'b0, readyIrq);
    wr(C0, 8'h00);
    wr(C0, 8'h42);
    core.busy <= 1'b1;
    accessHit <= 1'b1;
    @(posedge ref_clk);
    accessHit <= 1'b0;
    see("accessIrq", 1'b1, accessIrq);
    core.busy <= 1'b0;
    wrq(C0, 8'h52);
    see("seqReset", 1'b0, seqReset);
    wr(C1, 8'h00);
    wr(C1, 8'h08);
    see("lockBypass", 1'b1, lockBypass);
    core.busy <= 1'b1;
    wrq(C0, 8'h52);
    see("seqReset", 1'b1, seqReset);
    see("seqReset", 1'b0, seqReset);
    see("lockBypass", 1'b0, lockBypass);
    rd(C0, 8'h42, "ctl0");
    core.busy <= 1'b0;
    wr(C1, 8'h00);
    wr(C1, 8'h08);
    see("lockBypass", 1'b1, lockBypass);
    wr(C0, 8'h4a);
    see("flashStop", 1'b1, flashStop);
    see("romReadAllow", 1'b0, romReadAllow);
    see("cmdDrop", 1'b1, cmdDrop);
    see("lockBypass", 1'b0, lockBypass);
    wr(ST, 8'h00);
    see("accessIrq", 1'b0, accessIrq);
    wr(C0, 8'h00);
    wr(C0, 8'h08);
    see("flashStop", 1'b0, flashStop);
    sleepReq <= 1'b1;
    see("flashPowerOff", 1'b1, flashPowerOff);
    wr(C0, 8'h02);
    see("flashPowerOff", 1'b0, flashPowerOff);
    sleepReq <= 1'b0;
    // A write while the clock enable is low must leave control 0 as it was
    clkEn <= 1'b0;
    wr(C0, 8'h00);
    clkEn <= 1'b1;
    rd(C0, 8'h02, "ctl0");
    report_and_stop();
  end
endmodule
